// >>> rcp_params.svh
// register offsets, field positions, reset values and timing counts for the
// rollover counter / prescaler block; assumes a 32-bit AXI4-Lite register bus
`ifndef RCP_PARAMS_SVH
`define RCP_PARAMS_SVH

// byte addresses of the registers
`define RCP_ADDR_COUNT      12'h000
`define RCP_ADDR_OPTION     12'h004
`define RCP_ADDR_CONFIG     12'h008
`define RCP_ADDR_T1CTLB     12'h00c
`define RCP_ADDR_GUARD      12'h010
`define RCP_ADDR_STATUS     12'h014

// option register fields
`define RCP_OPT_FACTOR_LSB  0
`define RCP_OPT_ASSIGN_BIT  3
`define RCP_OPT_EDGE_BIT    4
`define RCP_OPT_SRC_BIT     5
`define RCP_OPT_IRQEN_N_BIT 6
`define RCP_OPT_REMAP_BIT   7
`define RCP_OPT_RESET       8'hff

// config register fields
`define RCP_CFG_EXT_FUSE_BIT  0
`define RCP_CFG_LARGE_BIT     1
`define RCP_CFG_PDOWN_BIT     2
`define RCP_CFG_GEN_BIT       3
`define RCP_CFG_RESET         8'h01

// guard register: write bit 0 = service, bit 1 = tick
`define RCP_GRD_SERVICE_BIT 0
`define RCP_GRD_TICK_BIT    1

// timer1 control b: pending flag position
`define RCP_PEND_BIT        7

// instruction cycle length in ns and divide count at 100 MHz
`define RCP_INSTR_NS        40
`define RCP_CLK_NS          10
`define RCP_INSTR_CYC       ((`RCP_INSTR_NS + `RCP_CLK_NS - 1) / `RCP_CLK_NS)

// irq vector
`define RCP_IRQ_VECTOR      16'h0000

`endif

// >>> rcp_pkg.sv
// types shared by the rollover counter / prescaler block
// assumes the params header sits beside it
package rcp_pkg;
  typedef struct packed {
    logic [7:0]  count;
    logic [7:0]  scaler;
    logic [7:0]  guard_cnt;
    logic [7:0]  option;
    logic [7:0]  config_bits;
    logic        pending;
    logic        pin_q;
    logic        pin_event;
    logic        scale_bit_q;
    logic        irq_req;
    logic        guard_rst;
    logic [7:0]  div_cnt;
    logic        aw_got;
    logic        w_got;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } rcp_state_s;
endpackage

// >>> rcp_counter.sv
// rollover counter with shared scaler, guard postscaler and AXI4-Lite regs
// assumes count_pin is synchronous to aclk and power-down is driven by cpu
//
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "rcp_params.svh"

// Summary of operation
// - 8-bit counter register, readable and writable, wraps over 256 values.
// - source bit 1 counts pin pulses, 0 counts instruction cycles.
// - pin source: edge bit 0 counts rising, 1 counts falling edges.
// - one 8-bit scaler, assigned either to counter or guard, never both.
// - assigned to counter: events advance scaler; chosen scaler bit clocks counter.
// - largest prescale is 256, giving a combined range of 65,536.
// - wrap FFh to 00h requests interrupt when enable-low bit is cleared.
// - irq enable and remap bits act only when extended fuse is zero.
// - instruction clock, no prescale: counter increments once per cycle.
// - software write loads counter; counting continues upward from it.
// - power-down stops the instruction clock and counting; counter keeps its value.
// - at most one pin event per instruction cycle.
// - larger variant: rollover sets pending flag at bit 7 of timer1 control b.
// - smaller variants have no pending flag; software reads the counter.
// - accepted interrupt vectors to 0000h; return resumes with context restored.
// - guard overflow after postscaling forces device reset, not interrupt.
// - guard postscale divisors 1 at 000 to 128 at 111, doubling.
// - guard service clears guard counter and shared scaler.
module rcp_counter
  import rcp_pkg::*;
#(
  parameter int INSTR_CYC = `RCP_INSTR_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        count_pin,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq_req,
  output logic [15:0]      irq_vector,
  output logic             guard_reset
);

  rcp_state_s st_r;
  rcp_state_s st_nxt;

  logic       instr_tick;
  logic       ext_ok;
  logic       to_counter;
  logic       pin_src;
  logic       cnt_event;
  logic       scaled_bit;
  logic [7:0] sc_inc;
  logic [7:0] gw_mask;
  logic       wr_fire;
  logic       rd_fire;
  logic [2:0] factor;

  // bus handshake and data outputs, irq request, vector and guard reset
  assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
  assign s_axi_wready  = !st_r.w_got && !st_r.bvalid;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_bvalid  = st_r.bvalid;
  assign s_axi_bresp   = st_r.bresp;
  assign s_axi_rvalid  = st_r.rvalid;
  assign s_axi_rdata   = st_r.rdata;
  assign s_axi_rresp   = st_r.rresp;
  assign irq_req       = st_r.irq_req;
  assign irq_vector    = `RCP_IRQ_VECTOR;
  assign guard_reset   = st_r.guard_rst;

  // decoded option and config bits, instruction tick, bus transfer strobes
  assign factor     = st_r.option[`RCP_OPT_FACTOR_LSB +: 3];
  assign to_counter = !st_r.option[`RCP_OPT_ASSIGN_BIT];
  assign pin_src    = st_r.option[`RCP_OPT_SRC_BIT];
  assign ext_ok     = !st_r.config_bits[`RCP_CFG_EXT_FUSE_BIT];
  assign instr_tick = (st_r.div_cnt == 8'(INSTR_CYC - 1))
                      && !st_r.config_bits[`RCP_CFG_PDOWN_BIT];
  assign wr_fire    = (st_r.aw_got || s_axi_awvalid) && (st_r.w_got || s_axi_wvalid)
                      && !st_r.bvalid;
  assign rd_fire    = s_axi_arvalid && !st_r.rvalid;

  // counted event: instruction tick or one latched pin edge per instruction cycle
  assign cnt_event  = instr_tick && (pin_src ? st_r.pin_event : 1'b1);

  // scaler increments, selected bit for prescale, masks for postscale
  assign sc_inc     = st_r.scaler + 8'h01;
  assign scaled_bit = sc_inc[factor];
  assign gw_mask    = 8'((16'h0001 << factor) - 16'h0001);

  // next-state logic
  always_comb begin
    logic       pin_edge;
    logic       adv;
    logic       wrap;
    logic       gtick;
    logic [11:0] wa;
    logic [31:0] wd;
    pin_edge = 1'b0;
    adv      = 1'b0;
    wrap     = 1'b0;
    gtick    = 1'b0;
    wa       = st_r.aw_got ? st_r.awaddr : s_axi_awaddr;
    wd       = st_r.w_got ? st_r.wdata : s_axi_wdata;
    st_nxt   = st_r;
    st_nxt.irq_req   = 1'b0;
    st_nxt.guard_rst = 1'b0;
    st_nxt.pin_q     = count_pin;

    // instruction clock divider
    if (!st_r.config_bits[`RCP_CFG_PDOWN_BIT]) begin
      st_nxt.div_cnt = instr_tick ? 8'h00 : st_r.div_cnt + 8'h01;
    end

    // pin edge detector, latched once until next instruction tick
    pin_edge = st_r.option[`RCP_OPT_EDGE_BIT] ? (st_r.pin_q && !count_pin)
                                              : (!st_r.pin_q && count_pin);
    if (instr_tick) begin
      st_nxt.pin_event = pin_edge;
    end else if (pin_edge) begin
      st_nxt.pin_event = 1'b1;
    end

    // counter advance through scaler or directly
    if (cnt_event) begin
      if (to_counter) begin
        st_nxt.scaler = sc_inc;
        adv = scaled_bit && !(st_r.scaler[factor]);
      end else begin
        adv = 1'b1;
      end
    end
    if (adv) begin
      st_nxt.count = st_r.count + 8'h01;
      wrap = (st_r.count == 8'hff);
    end
    if (wrap) begin
      if (ext_ok && !st_r.option[`RCP_OPT_IRQEN_N_BIT]) begin
        st_nxt.irq_req = 1'b1;
      end
      if (st_r.config_bits[`RCP_CFG_LARGE_BIT]) begin
        st_nxt.pending = 1'b1;
      end
    end

    // write channel capture
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end

    // register writes
    if (wr_fire) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = 2'b00;
      if ((st_r.w_got ? st_r.wstrb[0] : s_axi_wstrb[0])) begin
        unique case (wa)
          `RCP_ADDR_COUNT:  st_nxt.count       = wd[7:0];
          `RCP_ADDR_OPTION: st_nxt.option      = wd[7:0];
          `RCP_ADDR_CONFIG: st_nxt.config_bits = wd[7:0];
          `RCP_ADDR_T1CTLB: begin
            if (!wrap) begin
              st_nxt.pending = wd[`RCP_PEND_BIT];
            end
          end
          `RCP_ADDR_GUARD: begin
            if (wd[`RCP_GRD_SERVICE_BIT]) begin
              st_nxt.guard_cnt = 8'h00;
              st_nxt.scaler    = 8'h00;
            end else if (wd[`RCP_GRD_TICK_BIT]) begin
              gtick = 1'b1;
            end
          end
          default: st_nxt.bresp = 2'b10;
        endcase
      end else if (!(wa inside {`RCP_ADDR_COUNT, `RCP_ADDR_OPTION, `RCP_ADDR_CONFIG,
                               `RCP_ADDR_T1CTLB, `RCP_ADDR_GUARD, `RCP_ADDR_STATUS}))
      begin
        st_nxt.bresp = 2'b10;
      end
    end else if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // guard timer path with postscaler
    if (gtick) begin
      st_nxt.guard_cnt = st_r.guard_cnt + 8'h01;
      if (st_r.guard_cnt == 8'hff) begin
        if (to_counter) begin
          st_nxt.guard_rst = 1'b1;
        end else begin
          st_nxt.scaler = st_r.scaler + 8'h01;
          if ((st_r.scaler & gw_mask) == gw_mask) begin
            st_nxt.scaler    = 8'h00;
            st_nxt.guard_rst = 1'b1;
          end
        end
      end
    end

    // reads have no side effects
    if (rd_fire) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = 2'b00;
      unique case (s_axi_araddr)
        `RCP_ADDR_COUNT:  st_nxt.rdata = {24'h00_0000, st_r.count};
        `RCP_ADDR_OPTION: st_nxt.rdata = {24'h00_0000, st_r.option};
        `RCP_ADDR_CONFIG: st_nxt.rdata = {24'h00_0000, st_r.config_bits};
        `RCP_ADDR_T1CTLB: st_nxt.rdata = {24'h00_0000,
                                          st_r.pending && st_r.config_bits[`RCP_CFG_LARGE_BIT],
                                          7'h00};
        `RCP_ADDR_GUARD:  st_nxt.rdata = {24'h00_0000, st_r.guard_cnt};
        `RCP_ADDR_STATUS: st_nxt.rdata = {16'h0000, st_r.scaler, st_r.guard_cnt};
        default: begin
          st_nxt.rdata = 32'h0000_0000;
          st_nxt.rresp = 2'b10;
        end
      endcase
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end

    // remap bit only meaningful with extended fuse cleared
    if (!ext_ok) begin
      st_nxt.option[`RCP_OPT_REMAP_BIT] = 1'b1;
      st_nxt.option[`RCP_OPT_IRQEN_N_BIT] = 1'b1;
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r             <= '0;
      st_r.option      <= `RCP_OPT_RESET;
      st_r.config_bits <= `RCP_CFG_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule

// >>> rcp_pulse_src.sv
// event source model standing on the count pin
// assumes the pin is sampled on rising aclk edges
`timescale 1ns/1ps
module rcp_pulse_src (
  input  wire logic aclk,
  output logic      count_pin
);
  initial count_pin = 1'b0;

  // move the pin just after a rising edge and hold it
  task automatic set_level(input logic lvl);
    @(posedge aclk);
    count_pin <= lvl;
  endtask

  // pulses of the given phase length, short for prompt, long for slow
  task automatic pulses(input int n, input int ph);
    repeat (n) begin
      set_level(1'b1);
      repeat (ph - 1) @(posedge aclk);
      set_level(1'b0);
      repeat (ph - 1) @(posedge aclk);
    end
  endtask
endmodule

// >>> rcp_counter_checker.sv
// port-level checks of the rollover counter block
// assumes binding onto rcp_counter, one clock, sync active-low reset
`timescale 1ns/1ps
module rcp_counter_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        irq_req,
  input wire logic        guard_reset,
  input wire logic [15:0] irq_vector
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // read taken, then the answer with upper bits clear
  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_r_answer;
    s_axi_rvalid && s_axi_rdata[31:8] == 24'h00_0000;
  endsequence

  property p_read_answer; s_ar_take |=> s_r_answer; endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer late");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_w_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_w_busy: assert property (p_w_busy) else $error("write taken while busy");
  property p_r_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_r_busy: assert property (p_r_busy) else $error("read taken while busy");
  property p_irq_pulse; irq_req |=> !irq_req [*8]; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
  property p_guard_pulse; guard_reset |=> !guard_reset && !irq_req; endproperty
  a_guard_pulse: assert property (p_guard_pulse) else $error("guard pulse bad");
  property p_vector; irq_req |-> irq_vector == 16'h0000; endproperty
  a_vector: assert property (p_vector) else $error("irq vector wrong");
endmodule

bind rcp_counter rcp_counter_checker rcp_counter_checker_inst (.aclk, .aresetn, .s_axi_awready,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .irq_req, .guard_reset, .irq_vector);

// >>> rcp_counter_bench.sv
// self-checking bench of the rollover counter block
// assumes design, checker and pulse source model compiled first
`timescale 1ns/1ps
`include "rcp_params.svh"
module rcp_counter_bench;
  localparam int IC = 4;
  logic        aclk, aresetn, count_pin, irq_req, guard_reset;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v, w;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [15:0] irq_vector;
  int          n_errors, n_compared, n_irq, n_guard, k;

  rcp_counter #(.INSTR_CYC(IC)) rcp_counter_inst (.aclk, .aresetn, .count_pin, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_req, .irq_vector,
    .guard_reset);
  rcp_pulse_src rcp_pulse_src_inst (.aclk, .count_pin);

  // clock and pulse counters
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    n_irq <= n_irq + (irq_req === 1'b1);
    n_guard <= n_guard + (guard_reset === 1'b1);
  end

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one write: address and data offered together, released when taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic ta, tw, tb;
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tb = s_axi_bvalid;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      n++;
    end while (!tb && n < 40);
    s_axi_bready <= 1'b0;
    if (!tb) begin
      n_errors++;
      stop_test();
    end
  endtask

  // one read, data and response taken with rvalid
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rs);
    logic ta, tr;
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      n++;
    end while (!tr && n < 40);
    s_axi_rready <= 1'b0;
    if (!tr) begin
      n_errors++;
      stop_test();
    end
  endtask

  // count advance since the last read
  task automatic step(input string what, input logic [7:0] exp);
    rd(`RCP_ADDR_COUNT, w, r);
    check(what, {24'h00_0000, w[7:0] - v[7:0]}, {24'h00_0000, exp});
    v = w;
  endtask

  // advance over an exact window of clocks
  task automatic rate(input logic [7:0] opt, input int clocks, input logic [7:0] exp);
    wr(`RCP_ADDR_OPTION, opt);
    rd(`RCP_ADDR_COUNT, v, r);
    // the two read captures then lie exactly clocks edges apart
    repeat (clocks - 3) @(posedge aclk);
    step("count_rate", exp);
  endtask

  // main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`RCP_ADDR_OPTION, v, r);
    check("option", v, 32'h0000_00ff);
    rd(`RCP_ADDR_COUNT, v, r);
    check("count", v, 32'h0000_0000);
    check("vector", {16'h0000, irq_vector}, 32'h0000_0000);
    rd(12'h018, w, r);
    check("resp", {30'h0000_0000, r}, 32'h0000_0002);
    wr(`RCP_ADDR_OPTION, 8'h28);
    rcp_pulse_src_inst.pulses(2, 8);
    rcp_pulse_src_inst.pulses(2, 4);
    repeat (12) @(posedge aclk);
    step("pin_rise", 8'h04);
    wr(`RCP_ADDR_OPTION, 8'h38);
    rd(`RCP_ADDR_COUNT, v, r);
    rcp_pulse_src_inst.set_level(1'b1);
    repeat (12) @(posedge aclk);
    step("pin_fall_up", 8'h00);
    rcp_pulse_src_inst.set_level(1'b0);
    repeat (12) @(posedge aclk);
    step("pin_fall_down", 8'h01);
    rate(8'h08, 10 * IC, 8'h0a);
    for (int f = 0; f < 8; f++) rate(8'(f), 2 * IC << (f + 1), 8'h02);
    wr(`RCP_ADDR_CONFIG, 8'h04);
    rate(8'h08, 10 * IC, 8'h00);
    wr(`RCP_ADDR_COUNT, 8'hf0);
    k = n_irq;
    wr(`RCP_ADDR_CONFIG, 8'h02);
    repeat (56) @(posedge aclk);
    check("irq_early", n_irq - k, 0);
    repeat (12) @(posedge aclk);
    check("irq_wrap", n_irq - k, 1);
    rd(`RCP_ADDR_T1CTLB, v, r);
    check("pending", v, 32'h0000_0080);
    wr(`RCP_ADDR_CONFIG, 8'h04);
    wr(`RCP_ADDR_COUNT, 8'hf0);
    k = n_irq;
    wr(`RCP_ADDR_CONFIG, 8'h01);
    repeat (68) @(posedge aclk);
    check("irq_fused", n_irq - k, 0);
    wr(`RCP_ADDR_CONFIG, 8'h00);
    rd(`RCP_ADDR_T1CTLB, v, r);
    check("small_pending", v, 32'h0000_0000);
    wr(`RCP_ADDR_CONFIG, 8'h01);
    k = n_guard;
    wr(`RCP_ADDR_GUARD, 8'h01);
    repeat (255) wr(`RCP_ADDR_GUARD, 8'h02);
    check("guard_early", n_guard - k, 0);
    wr(`RCP_ADDR_GUARD, 8'h02);
    repeat (4) @(posedge aclk);
    check("guard_fire", n_guard - k, 1);
    stop_test();
  end
endmodule
